// ===== common/wdt_reset_regs.vh
`ifndef WDT_RESET_REGS_VH
`define WDT_RESET_REGS_VH

// Reset sequencing counts
`define RST_POR_OSC_CYCLES      7'd66
`define RST_POR_CNT_WIDTH       7
`define RST_SETTLE_CLOCKS       5'd16
`define RST_SETTLE_CNT_WIDTH    5

// Watchdog reload layout
`define WDT_RELOAD_WIDTH        24
`define WDT_BYTE_WIDTH          8
`define WDT_UPPER_LSB           16
`define WDT_HIGH_LSB            8
`define WDT_LOW_LSB             0

// Reload reset values
`define WDT_UPPER_RESET         8'h00
`define WDT_HIGH_RESET          8'h04
`define WDT_LOW_RESET           8'h00

// Refresh lockout, least legal reload and terminal count
`define WDT_NO_REFRESH_COUNT    24'h000002
`define WDT_MIN_RELOAD          24'h000004
`define WDT_TERMINAL_COUNT      24'h000001

// Watchdog oscillator timing
`define WDT_OSC_FREQ_HZ         10000
`define WDT_MS_PER_S            1000
`define WDT_TICKS_PER_MS        (`WDT_OSC_FREQ_HZ / `WDT_MS_PER_S)

`endif

// ===== src/tick_counter.v
`include "wdt_reset_regs.vh"

module tick_counter #(
  parameter WIDTH = 7,
  parameter [WIDTH-1:0] TERMINAL = 7'd66
) (
  input  wire clk,
  input  wire rst,
  input  wire clear,
  input  wire step,
  output reg  done
);

  reg [WIDTH-1:0] count;

  // Counts steps until done or cleared; count and done hold until cleared
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
      done  <= 1'b0;
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
      done  <= 1'b0;
    end else if (step && !done) begin
      if (count == TERMINAL - {{(WIDTH-1){1'b0}}, 1'b1}) begin
        done <= 1'b1;
      end
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ===== src/watchdog_counter.v
`include "wdt_reset_regs.vh"

module watchdog_counter (
  input  wire                         clk,
  input  wire                         rst,
  input  wire                         load,
  input  wire                         run,
  input  wire                         tick,
  input  wire [`WDT_RELOAD_WIDTH-1:0] reloadValue,
  output reg  [`WDT_RELOAD_WIDTH-1:0] count,
  output reg                          expire,
  output wire                         refreshAllowed
);

  // Near the end a late refresh must not rescue a stuck program
  assign refreshAllowed = (count > `WDT_NO_REFRESH_COUNT); // RL17

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count  <= {`WDT_UPPER_RESET, `WDT_HIGH_RESET, `WDT_LOW_RESET};
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        count <= reloadValue; // RL20
      end else if (run && tick) begin // RL11
        if (count <= `WDT_TERMINAL_COUNT) begin
          // Terminal count: fire and rearm from reload
          count  <= reloadValue; // RL9
          expire <= 1'b1; // RL9
        end else begin
          count <= count - `WDT_TERMINAL_COUNT;
        end
      end
    end
  end

endmodule

// ===== src/watchdog_and_reset_sequencer.v
// Contract
// (RL1) Supply above power-on threshold starts 66 watchdog-oscillator cycle count under reset.
// (RL2) After that count, 16 system clocks settle before reset may release.
// (RL3) System reset holds until both counters have expired; a watchdog reset here waits for the settle count only.
// (RL4) On release the processor starts by fetching the reset vector.
// (RL5) Completed power-on reset sets the power-on status flag.
// (RL6) Supply below brown-out threshold forces system reset.
// (RL7) Below power-on threshold reset holds; rising again reruns the whole sequence.
// (RL8) Brown-out detector in stop mode follows the brown-out keep option.
// (RL9) Watchdog is a retriggerable one-shot; terminal count fires its response.
// (RL10) Watchdog response selectable as system reset or interrupt request.
// (RL11) Watchdog counter steps only on its own oscillator.
// (RL12) Watchdog is off or on; once on it counts until refreshed.
// (RL13) Refresh instruction or always-on option switches the watchdog on.
// (RL14) With always-on option the watchdog runs from reset without refresh.
// (RL15) Watchdog is a 24-bit down-counter reloaded from three byte registers.
// (RL16) Reload value is upper byte, high byte, low byte, upper most significant.
// (RL17) Refresh requests are ignored once the count reaches 000002H.
// (RL18) Software never programs a reload value below 000004H.
// (RL19) Nominal time-out in milliseconds is reload divided by ten.
// (RL20) Each accepted refresh loads the reload value and restarts counting.
`include "wdt_reset_regs.vh"

module watchdog_and_reset_sequencer (
  input  wire                         clk,
  input  wire                         rst,
  input  wire                         supplyAbovePor,
  input  wire                         brownoutDetector,
  input  wire                         stopMode,
  input  wire                         brownoutStopKeepOption,
  input  wire                         watchdogAlwaysOnOption,
  input  wire                         wdtOscTick,
  input  wire                         watchdogRefreshInstruction,
  input  wire                         timeoutSelectsInterrupt,
  input  wire [`WDT_BYTE_WIDTH-1:0]   writeData,
  input  wire                         writeReloadUpperByte,
  input  wire                         writeReloadHighByte,
  input  wire                         writeReloadLowByte,
  input  wire                         clearPowerOnStatus,
  input  wire                         clearWatchdogStatus,
  input  wire                         clearBrownoutStatus,
  output reg                          systemReset,
  output reg                          fetchResetVector,
  output reg                          powerOnStatus,
  output reg                          watchdogResetStatus,
  output reg                          brownoutStatus,
  output reg                          watchdogInterrupt,
  output reg                          watchdogRunning,
  output reg                          brownoutEnable,
  output reg  [`WDT_BYTE_WIDTH-1:0]   reloadUpperByte,
  output reg  [`WDT_BYTE_WIDTH-1:0]   reloadHighByte,
  output reg  [`WDT_BYTE_WIDTH-1:0]   reloadLowByte,
  output wire [`WDT_RELOAD_WIDTH-1:0] watchdogCount,
  output reg  [`WDT_RELOAD_WIDTH-1:0] nominalTimeoutMs,
  output reg                          reloadBelowMinimum
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states

  localparam [3:0] ST_HOLD   = 4'h1;
  localparam [3:0] ST_POR    = 4'h2;
  localparam [3:0] ST_SETTLE = 4'h4;
  localparam [3:0] ST_RUN    = 4'h8;

  reg  [3:0]                   state;
  reg  [3:0]                   next_state;
  reg                          passedPor;
  reg                          enabledByInstruction;

  wire                         brownoutEnableNow;
  wire                         brownoutActive;
  wire                         supplyLost;
  wire                         porDone;
  wire                         settleDone;
  wire                         wdExpire;
  wire                         refreshAllowed;
  wire                         watchdogOn;
  wire                         refreshAccepted;
  wire                         watchdogLoad;
  wire                         watchdogResetEvent;
  wire                         watchdogIrqEvent;
  wire                         enterRun;
  wire [`WDT_RELOAD_WIDTH-1:0] reloadValue;

  ////////////////////////////////////////////////////////////////////////////
  // Supply supervision

  // Detector stays live in stop mode only when the keep option is set
  assign brownoutEnableNow = !stopMode || brownoutStopKeepOption; // RL8
  assign brownoutActive    = brownoutEnableNow && brownoutDetector; // RL6
  assign supplyLost        = brownoutActive || !supplyAbovePor; // RL7

  ////////////////////////////////////////////////////////////////////////////
  // Power-on and settle counters

  tick_counter #(
    .WIDTH    (`RST_POR_CNT_WIDTH),
    .TERMINAL (`RST_POR_OSC_CYCLES)
  ) u_por_counter (
    .clk   (clk),
    .rst   (rst),
    .clear (state != ST_POR),
    .step  (wdtOscTick), // RL1
    .done  (porDone)
  );

  tick_counter #(
    .WIDTH    (`RST_SETTLE_CNT_WIDTH),
    .TERMINAL (`RST_SETTLE_CLOCKS)
  ) u_settle_counter (
    .clk   (clk),
    .rst   (rst),
    .clear (state != ST_SETTLE),
    .step  (1'b1), // RL2
    .done  (settleDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Supply loss always wins and restarts from hold, so a dip during
  // the settle count cannot shortcut the oscillator count.
  // A watchdog reset only reruns the settle count: the supply never
  // left its range, so the oscillator count adds nothing.
  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!supplyLost) begin
          next_state = ST_POR; // RL1
        end
      end
      ST_POR: begin
        if (supplyLost) begin
          next_state = ST_HOLD; // RL7
        end else if (porDone) begin
          next_state = ST_SETTLE; // RL2
        end
      end
      ST_SETTLE: begin
        if (supplyLost) begin
          next_state = ST_HOLD; // RL7
        end else if (settleDone) begin
          next_state = ST_RUN; // RL3
        end
      end
      ST_RUN: begin
        if (supplyLost) begin
          next_state = ST_HOLD; // RL6
        end else if (watchdogResetEvent) begin
          next_state = ST_SETTLE; // RL10
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  assign enterRun = (state != ST_RUN) && (next_state == ST_RUN);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state            <= ST_HOLD;
      systemReset      <= 1'b1;
      fetchResetVector <= 1'b0;
      passedPor        <= 1'b0;
    end else begin
      state            <= next_state;
      // Reset stays on in every state but run
      systemReset      <= (next_state != ST_RUN); // RL3
      fetchResetVector <= enterRun; // RL4
      // Remembers that this release follows a power-on count,
      // so a watchdog reset does not raise the power-on flag
      if (state == ST_POR) begin
        passedPor <= 1'b1;
      end else if (enterRun) begin
        passedPor <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause flags; a new event wins over a clear in the same cycle

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      powerOnStatus       <= 1'b0;
      watchdogResetStatus <= 1'b0;
      brownoutStatus      <= 1'b0;
    end else begin
      if (enterRun && passedPor) begin
        powerOnStatus <= 1'b1; // RL5
      end else if (clearPowerOnStatus) begin
        powerOnStatus <= 1'b0;
      end
      if (watchdogResetEvent || watchdogIrqEvent) begin
        watchdogResetStatus <= 1'b1;
      end else if (clearWatchdogStatus) begin
        watchdogResetStatus <= 1'b0;
      end
      if (brownoutActive && state != ST_HOLD) begin
        brownoutStatus <= 1'b1;
      end else if (clearBrownoutStatus) begin
        brownoutStatus <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reload byte registers

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reloadUpperByte <= `WDT_UPPER_RESET;
      reloadHighByte  <= `WDT_HIGH_RESET;
      reloadLowByte   <= `WDT_LOW_RESET;
    end else begin
      if (writeReloadUpperByte) begin
        reloadUpperByte <= writeData; // RL15
      end
      if (writeReloadHighByte) begin
        reloadHighByte <= writeData; // RL15
      end
      if (writeReloadLowByte) begin
        reloadLowByte <= writeData; // RL15
      end
    end
  end

  assign reloadValue = {reloadUpperByte, reloadHighByte, reloadLowByte}; // RL16

  ////////////////////////////////////////////////////////////////////////////
  // Time-out estimate

  // Divide at full integer width, then cut; reload over ten always fits 24 bits
  wire [31:0]                  timeoutQuotient;

  assign timeoutQuotient = {8'h00, reloadValue} / `WDT_TICKS_PER_MS; // RL19

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog control

  // Instruction-enable is lost on any system reset; the option is not
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enabledByInstruction <= 1'b0;
    end else if (state != ST_RUN) begin
      enabledByInstruction <= 1'b0;
    end else if (watchdogRefreshInstruction) begin
      enabledByInstruction <= 1'b1; // RL13
    end
  end

  assign watchdogOn = (state == ST_RUN) &&
                      (enabledByInstruction || watchdogAlwaysOnOption || watchdogRefreshInstruction); // RL14
  assign refreshAccepted = watchdogRefreshInstruction && (state == ST_RUN) && refreshAllowed; // RL17
  // While off the count shadows the reload so switching on starts fresh
  assign watchdogLoad = !watchdogOn || refreshAccepted; // RL20

  watchdog_counter u_watchdog_counter (
    .clk            (clk),
    .rst            (rst),
    .load           (watchdogLoad),
    .run            (watchdogOn), // RL12
    .tick           (wdtOscTick), // RL11
    .reloadValue    (reloadValue),
    .count          (watchdogCount),
    .expire         (wdExpire),
    .refreshAllowed (refreshAllowed)
  );

  // Response select is read at expiry, not latched at enable
  assign watchdogResetEvent = wdExpire && !timeoutSelectsInterrupt && (state == ST_RUN); // RL10
  assign watchdogIrqEvent   = wdExpire && timeoutSelectsInterrupt && (state == ST_RUN); // RL10

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdogInterrupt  <= 1'b0;
      watchdogRunning    <= 1'b0;
      brownoutEnable     <= 1'b1;
      nominalTimeoutMs   <= {`WDT_RELOAD_WIDTH{1'b0}};
      reloadBelowMinimum <= 1'b0;
    end else begin
      watchdogInterrupt  <= watchdogIrqEvent; // RL10
      watchdogRunning    <= watchdogOn; // RL12
      brownoutEnable     <= brownoutEnableNow; // RL8
      // Divider is combinational but only follows rare reload writes
      nominalTimeoutMs   <= timeoutQuotient[`WDT_RELOAD_WIDTH-1:0]; // RL19
      // Flags a reload that risks a time-out no refresh can stop
      reloadBelowMinimum <= (reloadValue < `WDT_MIN_RELOAD); // RL18
    end
  end

endmodule

// ===== dv/wdt_seq_asserts.sv
module wdt_seq_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        supplyAbovePor,
  input wire logic        brownoutDetector,
  input wire logic        stopMode,
  input wire logic        wdtOscTick,
  input wire logic        watchdogRefreshInstruction,
  input wire logic        timeoutSelectsInterrupt,
  input wire logic        writeReloadUpperByte,
  input wire logic        writeReloadHighByte,
  input wire logic        writeReloadLowByte,
  input wire logic        clearPowerOnStatus,
  input wire logic        systemReset,
  input wire logic        fetchResetVector,
  input wire logic        powerOnStatus,
  input wire logic        watchdogInterrupt,
  input wire logic        watchdogRunning,
  input wire logic [7:0]  reloadUpperByte,
  input wire logic [7:0]  reloadHighByte,
  input wire logic [7:0]  reloadLowByte,
  input wire logic [23:0] watchdogCount
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Supply good and core running, so only the watchdog moves the count
  wire        quiet  = supplyAbovePor && !brownoutDetector && !systemReset;
  wire        noWr   = !(writeReloadUpperByte || writeReloadHighByte || writeReloadLowByte);
  wire [23:0] reload = {reloadUpperByte, reloadHighByte, reloadLowByte};
  wire        wdOn   = quiet && watchdogRunning;

  release_fetch_a: assert property ($fell(systemReset) |-> fetchResetVector)
    else $error("no vector fetch at release");
  fetch_single_a: assert property (fetchResetVector |=> !fetchResetVector)
    else $error("vector fetch longer than one cycle");
  settle_hold_a: assert property ($fell(systemReset) |-> $past(systemReset, 16))
    else $error("reset released before settle count");
  brownout_reset_a: assert property (brownoutDetector && !stopMode |=> systemReset)
    else $error("brown-out did not force reset");
  supply_low_a: assert property (!supplyAbovePor |=> systemReset)
    else $error("reset not held with low supply");
  refresh_load_a: assert property (watchdogRefreshInstruction && quiet && noWr
    && watchdogCount > 24'h000002 |=> watchdogCount == $past(reload))
    else $error("refresh did not load reload value");
  refresh_late_a: assert property (watchdogRefreshInstruction && wdOn && !wdtOscTick
    && watchdogCount == 24'h000002 |=> watchdogCount == 24'h000002)
    else $error("late refresh was accepted");
  count_step_a: assert property (wdOn && wdtOscTick && !watchdogRefreshInstruction
    && watchdogCount > 24'h000002 |=> watchdogCount == $past(watchdogCount) - 24'h000001)
    else $error("count did not step down on tick");
  osc_only_a: assert property (wdOn && !wdtOscTick && !watchdogRefreshInstruction && noWr
    && watchdogCount > 24'h000001 |=> $stable(watchdogCount))
    else $error("count moved without oscillator tick");
  timeout_irq_a: assert property (wdOn && wdtOscTick && watchdogCount == 24'h000001
    && timeoutSelectsInterrupt |-> ##[1:3] watchdogInterrupt)
    else $error("time-out gave no interrupt");
  timeout_rst_a: assert property (wdOn && wdtOscTick && watchdogCount == 24'h000001
    && !timeoutSelectsInterrupt |-> ##[1:3] systemReset)
    else $error("time-out gave no reset");
  por_sticky_a: assert property (powerOnStatus && !clearPowerOnStatus |=> powerOnStatus)
    else $error("power-on flag lost");
endmodule

bind watchdog_and_reset_sequencer wdt_seq_asserts i_chk (.*);

// ===== dv/osc_tick_model.sv
module osc_tick_model #(parameter int PERIOD = 4) (
  input  wire logic clk,
  output logic      wdtOscTick
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase = 0;
  initial wdtOscTick = 1'b0;
  // Runs free like the RC source; sped up so the 66-tick count stays short
  always @(negedge clk) begin
    phase <= (phase + 1) % PERIOD;
    wdtOscTick <= (phase == PERIOD - 1);
  end
endmodule

// ===== dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, supplyAbovePor, brownoutDetector, stopMode, brownoutStopKeepOption;
  logic watchdogAlwaysOnOption, wdtOscTick, watchdogRefreshInstruction, timeoutSelectsInterrupt;
  logic writeReloadUpperByte, writeReloadHighByte, writeReloadLowByte;
  logic clearPowerOnStatus, clearWatchdogStatus, clearBrownoutStatus;
  logic systemReset, fetchResetVector, powerOnStatus, watchdogResetStatus, brownoutStatus;
  logic watchdogInterrupt, watchdogRunning, brownoutEnable, reloadBelowMinimum;
  logic [7:0]  writeData, reloadUpperByte, reloadHighByte, reloadLowByte;
  logic [23:0] watchdogCount, nominalTimeoutMs;
  int mismatches = 0;
  int nChecks = 0;
  int cycles = 0;

  watchdog_and_reset_sequencer i_dut (.*);
  osc_tick_model i_osc (.clk(clk), .wdtOscTick(wdtOscTick));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic wr(ref logic s, input logic [7:0] d);
    writeData = d;
    pulse(s);
  endtask

  task automatic waitBit(ref logic s, input logic v);
    int i;
    i = 0;
    while (s !== v && i < 3000) begin
      @(negedge clk);
      i++;
    end
    chk("wait bit", s, v);
  endtask

  task automatic waitCnt(input logic [23:0] v);
    int i;
    i = 0;
    while (watchdogCount !== v && i < 3000) begin
      @(negedge clk);
      i++;
    end
    chk("wait count", watchdogCount, v);
  endtask

  // Counts oscillator ticks up to release; settle clocks add a few more
  task automatic powerUp();
    int n;
    n = 0;
    supplyAbovePor = 1'b1;
    while (systemReset !== 1'b0 && n < 500) begin
      @(negedge clk);
      if (wdtOscTick)
        n++;
    end
    chk("por ticks", n >= 66 && n <= 72, 1'b1);
    chk("vector fetch", fetchResetVector, 1'b1);
    @(negedge clk);
    chk("fetch ends", fetchResetVector, 1'b0);
    chk("por flag", powerOnStatus, 1'b1);
    $display("test power-up done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    {rst, supplyAbovePor, brownoutDetector, stopMode, brownoutStopKeepOption} = 5'h10;
    {watchdogAlwaysOnOption, watchdogRefreshInstruction, timeoutSelectsInterrupt} = 3'h0;
    {writeReloadUpperByte, writeReloadHighByte, writeReloadLowByte} = 3'h0;
    {clearPowerOnStatus, clearWatchdogStatus, clearBrownoutStatus} = 3'h0;
    writeData = 8'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    powerUp();
    wr(writeReloadUpperByte, 8'h01);
    wr(writeReloadHighByte, 8'h02);
    wr(writeReloadLowByte, 8'h03);
    @(negedge clk);
    chk("byte order", watchdogCount, 24'h010203);
    chk("timeout ms", nominalTimeoutMs, 24'h0019cd);
    wr(writeReloadUpperByte, 8'h00);
    wr(writeReloadHighByte, 8'h00);
    @(negedge clk);
    chk("below min", reloadBelowMinimum, 1'b1);
    wr(writeReloadLowByte, 8'h1e);
    @(negedge clk);
    chk("legal min", reloadBelowMinimum, 1'b0);
    timeoutSelectsInterrupt = 1'b1;
    chk("wd off", watchdogRunning, 1'b0);
    pulse(watchdogRefreshInstruction);
    chk("load", watchdogCount, 24'h00001e);
    chk("wd on", watchdogRunning, 1'b1);
    waitCnt(24'h00000a);
    pulse(watchdogRefreshInstruction);
    chk("retrigger", watchdogCount, 24'h00001e);
    waitCnt(24'h000002);
    pulse(watchdogRefreshInstruction);
    chk("late refresh", watchdogCount <= 24'h000002, 1'b1);
    waitBit(watchdogInterrupt, 1'b1);
    chk("irq no reset", systemReset, 1'b0);
    chk("irq flag", watchdogResetStatus, 1'b1);
    $display("test watchdog interrupt done");
    pulse(clearWatchdogStatus);
    chk("wd clear", watchdogResetStatus, 1'b0);
    pulse(clearPowerOnStatus);
    chk("por clear", powerOnStatus, 1'b0);
    timeoutSelectsInterrupt = 1'b0;
    pulse(watchdogRefreshInstruction);
    waitBit(systemReset, 1'b1);
    chk("wd status", watchdogResetStatus, 1'b1);
    waitBit(systemReset, 1'b0);
    chk("no por flag", powerOnStatus, 1'b0);
    chk("wd off again", watchdogRunning, 1'b0);
    $display("test watchdog reset done");
    timeoutSelectsInterrupt = 1'b1;
    brownoutDetector = 1'b1;
    repeat (2) @(negedge clk);
    chk("bo reset", systemReset, 1'b1);
    chk("bo flag", brownoutStatus, 1'b1);
    stopMode = 1'b1;
    repeat (2) @(negedge clk);
    chk("bo stop off", brownoutEnable, 1'b0);
    brownoutStopKeepOption = 1'b1;
    repeat (2) @(negedge clk);
    chk("bo stop on", brownoutEnable, 1'b1);
    {stopMode, brownoutDetector, supplyAbovePor} = 3'h0;
    repeat (3) @(negedge clk);
    chk("low supply", systemReset, 1'b1);
    pulse(clearBrownoutStatus);
    chk("bo clear", brownoutStatus, 1'b0);
    watchdogAlwaysOnOption = 1'b1;
    powerUp();
    repeat (3) @(negedge clk);
    chk("always on", watchdogRunning, 1'b1);
    $display("test brown-out done");
    summarize();
  end
endmodule
